/* File: core/cke_params.svh */
// Constants for the calculator key entry sequencer
`ifndef CKE_PARAMS_SVH
`define CKE_PARAMS_SVH
`define CKE_DIGIT_W       4
`define CKE_DIGITS        13
`define CKE_DC_W          4
`define CKE_POINT_W       4
`define CKE_POINT_PRESET  4'h4
`define CKE_POINT_ZERO    4'h0
`define CKE_ROWS          5
`define CKE_COLS          4
`define CKE_ROW_W         3
`define CKE_ROW_DWELL     16
`define CKE_CODE_W        4
`define CKE_CODE_POINT    4'hA
`define CKE_CODE_MUL      4'hB
`define CKE_CODE_DIV      4'hC
`define CKE_CODE_BLANK    4'hF
`define CKE_GLYPH_W       20
`endif

/* File: core/cke_pkg.sv */
// Types shared by the key entry sequencer files
`include "cke_params.svh"
package cke_pkg;
  typedef enum logic [2:0] {
    ST_ZERO,
    ST_PRINT,
    ST_FIVE,
    ST_FOUR,
    ST_ONE
  } cke_state_t;

  typedef enum logic [1:0] {
    KEY_NUMERAL,
    KEY_POINT,
    KEY_MUL,
    KEY_DIV
  } cke_key_kind_t;

  typedef struct packed {
    cke_key_kind_t           kind;
    logic [`CKE_CODE_W-1:0]  digit;
  } cke_key_t;

  typedef struct packed {
    logic in_number;
    logic [`CKE_CODE_W-1:0] code;
  } cke_input_reg_t;

  typedef struct packed {
    logic new_entry_flag;
    logic decimal_point_flag;
    logic constant_flag;
    logic multiply_select_flag;
    logic muldiv_select_flag;
    logic sign_flag;
  } cke_flags_t;
endpackage : cke_pkg

/* File: core/cke_character_generator.sv */
// Character generator: code and row to head column pattern
`timescale 1ns/1ps
`default_nettype none
`include "cke_params.svh"
module cke_character_generator (
  // Character select
  input  wire logic [`CKE_CODE_W-1:0] code_in,
  input  wire logic [`CKE_ROW_W-1:0]  row_in,
  // Column pattern
  output logic      [`CKE_COLS-1:0]   cols_out
);
  import cke_pkg::*;

  // Top row sits in the most significant nibble
  function automatic logic [`CKE_GLYPH_W-1:0] glyph(input logic [`CKE_CODE_W-1:0] c);
    case (c)
      4'h0:            glyph = 20'h69996;
      4'h1:            glyph = 20'h26227;
      4'h2:            glyph = 20'h6924F;
      4'h3:            glyph = 20'hE161E;
      4'h4:            glyph = 20'h99F11;
      4'h5:            glyph = 20'hF8E1E;
      4'h6:            glyph = 20'h68E96;
      4'h7:            glyph = 20'hF1244;
      4'h8:            glyph = 20'h69696;
      4'h9:            glyph = 20'h69716;
      `CKE_CODE_POINT: glyph = 20'h00004;
      `CKE_CODE_MUL:   glyph = 20'h09690;
      `CKE_CODE_DIV:   glyph = 20'h04F40;
      default:         glyph = 20'h00000;
    endcase
  endfunction : glyph

  logic [`CKE_GLYPH_W-1:0] pat;
  logic [`CKE_GLYPH_W-1:0] sh;

  always_comb begin
    pat      = glyph(code_in);
    sh       = pat >> (5'(`CKE_ROWS - 1 - 32'(row_in)) * 5'(`CKE_COLS));
    cols_out = sh[`CKE_COLS-1:0];
  end
endmodule : cke_character_generator
`default_nettype wire

/* File: core/cke_print_timing.sv */
// Print timing: row (stroke) counter and per-row print counter
`timescale 1ns/1ps
`default_nettype none
`include "cke_params.svh"
module cke_print_timing #(
  parameter int ROWS  = `CKE_ROWS,
  parameter int DWELL = `CKE_ROW_DWELL
) (
  // Clocking
  input  wire logic                  core_clk_in,
  input  wire logic                  resetn_in,
  input  wire logic                  ce_in,
  // Control
  input  wire logic                  start_in,
  // Status
  output logic                       active_out,
  output logic [`CKE_ROW_W-1:0]      row_out,
  output logic                       done_out
);
  import cke_pkg::*;
  localparam int PCW = $clog2(DWELL + 1);
  localparam logic [PCW-1:0] PC_LAST = PCW'(DWELL - 1);
  localparam logic [`CKE_ROW_W-1:0] ROW_LAST = `CKE_ROW_W'(ROWS - 1);

  logic [PCW-1:0] print_counter_r;

  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      active_out      <= 1'b0;
      row_out         <= '0;
      print_counter_r <= '0;
      done_out        <= 1'b0;
    end else if (ce_in) begin
      done_out <= 1'b0;
      if (!active_out) begin
        if (start_in) begin
          active_out      <= 1'b1;
          row_out         <= '0;
          print_counter_r <= '0;
        end
      end else if (print_counter_r == PC_LAST) begin
        print_counter_r <= '0;
        if (row_out == ROW_LAST) begin
          active_out <= 1'b0;
          done_out   <= 1'b1;
        end else begin
          row_out <= row_out + 1'b1;
        end
      end else begin
        print_counter_r <= print_counter_r + 1'b1;
      end
    end
  end
endmodule : cke_print_timing
`default_nettype wire

/* File: core/cke_sequencer.sv */
// Key entry sequencer: digit, point and order key control
`timescale 1ns/1ps
`default_nettype none
`include "cke_params.svh"
module cke_sequencer #(
  parameter int DIGITS = `CKE_DIGITS,
  parameter int DWELL  = `CKE_ROW_DWELL
) (
  // Clocking
  input  wire logic                               core_clk_in,
  input  wire logic                               resetn_in,
  input  wire logic                               ce_in,
  // Keyboard
  input  wire logic                               key_valid_in,
  input  wire cke_pkg::cke_key_t                  key_in,
  input  wire logic                               key_release_signal_in,
  input  wire logic                               clear_key_in,
  // Print head
  output logic [`CKE_COLS-1:0]                    head_column_output_out,
  output logic [`CKE_ROWS-1:0]                    head_row_out,
  output logic                                    print_busy_out,
  // Status
  output cke_pkg::cke_state_t                     state_out,
  output cke_pkg::cke_flags_t                     flags_out,
  output cke_pkg::cke_input_reg_t                 input_register_out,
  output logic [DIGITS*`CKE_DIGIT_W-1:0]          entry_buffer_out,
  output logic [DIGITS*`CKE_DIGIT_W-1:0]          upper_accumulator_out,
  output logic [`CKE_POINT_W-1:0]                 point_counter_out,
  output logic                                    halted_out
);
  import cke_pkg::*;
  localparam int DW = `CKE_DIGIT_W;
  localparam int BW = DIGITS * DW;
  localparam logic [`CKE_DC_W-1:0] DC_LAST = `CKE_DC_W'(DIGITS - 1);
  function automatic logic [DW-1:0] top_digit(input logic [BW-1:0] b);
    top_digit = b[BW-1 -: DW];
  endfunction : top_digit
  // Position zero wraps onto the top digit, which is what makes underflow visible
  function automatic logic [`CKE_DC_W-1:0] insert_index(input logic [`CKE_POINT_W-1:0] p);
    insert_index = (p == `CKE_POINT_ZERO) ? DC_LAST : `CKE_DC_W'(p - 1'b1);
  endfunction : insert_index
  cke_state_t                  state_r;
  cke_state_t                  state_nxt;
  cke_flags_t                  flags_r;
  cke_input_reg_t              input_register_r;
  cke_key_kind_t               key_kind_r;
  logic [BW-1:0]               entry_buffer_r;
  logic [BW-1:0]               entry_buffer_nxt;
  logic [BW-1:0]               upper_accumulator_r;
  logic [`CKE_POINT_W-1:0]     point_counter_r;
  logic [`CKE_DC_W-1:0]        digit_counter_r;
  logic                        key_pending_r;
  logic                        blank_pending_r;
  logic                        blank_print_r;
  logic                        print_issued_r;
  logic                        print_done_r;
  logic                        print_start;
  logic                        word_end;
  logic                        top_busy;
  logic                        key_take;
  logic                        tm_active;
  logic [`CKE_ROW_W-1:0]       tm_row;
  logic                        tm_done;
  logic [`CKE_COLS-1:0]        cg_cols;

  assign word_end    = (digit_counter_r == DC_LAST);
  assign top_busy    = (top_digit(entry_buffer_r) != '0);
  assign key_take    = key_valid_in && (state_r == ST_ZERO) && !key_pending_r && !top_busy;
  assign print_start = (state_r == ST_PRINT) && !print_issued_r;
  assign state_out             = state_r;
  assign flags_out             = flags_r;
  assign input_register_out    = input_register_r;
  assign entry_buffer_out      = entry_buffer_r;
  assign upper_accumulator_out = upper_accumulator_r;
  assign point_counter_out     = point_counter_r;

  // Serial word timing: one digit per clock
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      digit_counter_r <= '0;
    end else if (ce_in) begin
      digit_counter_r <= word_end ? '0 : digit_counter_r + 1'b1;
    end
  end

  // Key capture into the input register
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      input_register_r <= '0;
      key_kind_r       <= KEY_NUMERAL;
      key_pending_r    <= 1'b0;
    end else if (ce_in) begin
      if (clear_key_in) begin
        key_pending_r <= 1'b0;
      end else if (key_take) begin
        key_kind_r    <= key_in.kind;
        key_pending_r <= 1'b1;
        input_register_r.in_number <= (key_in.kind == KEY_NUMERAL);
        case (key_in.kind)
          KEY_NUMERAL: input_register_r.code <= key_in.digit;
          KEY_POINT:   input_register_r.code <= `CKE_CODE_POINT;
          KEY_MUL:     input_register_r.code <= `CKE_CODE_MUL;
          default:     input_register_r.code <= `CKE_CODE_DIV;
        endcase
      end else if (state_r == ST_ONE && blank_pending_r && !flags_r.decimal_point_flag && word_end) begin
        input_register_r.in_number <= 1'b0;
        input_register_r.code      <= `CKE_CODE_BLANK;
      end else if (state_r == ST_ONE && word_end) begin
        key_pending_r <= 1'b0;
      end
    end
  end

  // Control counter, changes only at word end or on the clear key
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      // Held top digit keeps everything frozen; no overflow action of its own
      ST_ZERO: if (key_pending_r && !top_busy) state_nxt = ST_PRINT;
      ST_PRINT: begin
        if (print_done_r) begin
          if (blank_print_r) begin
            state_nxt = ST_ONE;
          end else begin
            case (key_kind_r)
              KEY_NUMERAL: state_nxt = ST_FIVE;
              KEY_POINT:   state_nxt = ST_ONE;
              default:     state_nxt = ST_FOUR;
            endcase
          end
        end
      end
      ST_FIVE: if (flags_r.new_entry_flag) state_nxt = ST_ONE;
      ST_FOUR: state_nxt = ST_ONE;
      ST_ONE: begin
        if (blank_pending_r && !flags_r.decimal_point_flag) begin
          state_nxt = ST_PRINT;
        end else if (key_release_signal_in) begin
          state_nxt = ST_ZERO;
        end
      end
      default: state_nxt = ST_ZERO;
    endcase
  end
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_r <= ST_ZERO;
    end else if (ce_in) begin
      if (clear_key_in) begin
        state_r <= ST_ZERO;
      end else if (word_end) begin
        state_r <= state_nxt;
      end
    end
  end

  // Print issue and completion tracking
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      print_issued_r  <= 1'b0;
      print_done_r    <= 1'b0;
      blank_pending_r <= 1'b0;
      blank_print_r   <= 1'b0;
    end else if (ce_in) begin
      if (state_r != ST_PRINT) begin
        print_issued_r <= 1'b0;
        print_done_r   <= 1'b0;
      end else begin
        if (print_start) begin
          print_issued_r <= 1'b1;
        end
        if (tm_done) begin
          print_done_r <= 1'b1;
        end
      end
      if (clear_key_in) begin
        blank_pending_r <= 1'b0;
        blank_print_r   <= 1'b0;
      end else if (word_end && state_r == ST_FOUR) begin
        blank_pending_r <= 1'b1;
      end else if (word_end && state_r == ST_ONE && state_nxt == ST_PRINT) begin
        blank_pending_r <= 1'b0;
        blank_print_r   <= 1'b1;
      end else if (word_end && state_r == ST_PRINT && print_done_r) begin
        blank_print_r <= 1'b0;
      end
    end
  end

  // Buffer and accumulator recirculation, one digit per clock
  always_comb begin
    entry_buffer_nxt = entry_buffer_r;
    if (state_r == ST_FIVE && flags_r.new_entry_flag) begin
      entry_buffer_nxt = {entry_buffer_r[DW-1:0], entry_buffer_r[BW-1:DW]};
      if (digit_counter_r == insert_index(point_counter_r)) begin
        entry_buffer_nxt = {input_register_r.code, entry_buffer_r[BW-1:DW]};
      end
      if (word_end && !flags_r.decimal_point_flag) begin
        entry_buffer_nxt = {entry_buffer_nxt[BW-DW-1:0], {DW{1'b0}}};
      end
    end else if (state_r == ST_FOUR) begin
      entry_buffer_nxt = {entry_buffer_r[DW-1:0], entry_buffer_r[BW-1:DW]};
    end
  end
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      entry_buffer_r <= '0;
    end else if (ce_in) begin
      if (clear_key_in) begin
        entry_buffer_r <= '0;
      end else if (state_r == ST_FIVE && !flags_r.new_entry_flag) begin
        entry_buffer_r <= '0;
      end else begin
        entry_buffer_r <= entry_buffer_nxt;
      end
    end
  end
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      upper_accumulator_r <= '0;
    end else if (ce_in) begin
      if (clear_key_in) begin
        upper_accumulator_r <= '0;
      end else if (state_r == ST_FOUR) begin
        // Copying while recirculating lets a square be taken from one entry
        upper_accumulator_r <= {entry_buffer_r[DW-1:0], upper_accumulator_r[BW-1:DW]};
      end
    end
  end

  // Point counter
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      point_counter_r <= `CKE_POINT_PRESET;
    end else if (ce_in) begin
      if (clear_key_in) begin
        point_counter_r <= `CKE_POINT_PRESET;
      end else if (state_r == ST_FIVE && word_end) begin
        if (!flags_r.new_entry_flag) begin
          point_counter_r <= `CKE_POINT_PRESET;
        end else if (flags_r.decimal_point_flag && point_counter_r != `CKE_POINT_ZERO) begin
          point_counter_r <= point_counter_r - 1'b1;
        end
      end
    end
  end

  // Flags
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      flags_r <= '0;
    end else if (ce_in) begin
      if (clear_key_in) begin
        flags_r               <= '0;
        flags_r.constant_flag <= 1'b1;
      end else if (word_end) begin
        case (state_r)
          ST_FIVE: begin
            if (!flags_r.new_entry_flag) begin
              flags_r.new_entry_flag <= 1'b1;
            end else if (flags_r.constant_flag && flags_r.muldiv_select_flag &&
                         !flags_r.multiply_select_flag) begin
              flags_r.sign_flag <= 1'b0;
            end
          end
          ST_PRINT: begin
            if (print_done_r && !blank_print_r && key_kind_r == KEY_POINT) begin
              flags_r.decimal_point_flag <= 1'b1;
            end
          end
          ST_FOUR: begin
            if (flags_r.new_entry_flag && flags_r.sign_flag) begin
              flags_r.sign_flag <= 1'b0;
            end
            flags_r.decimal_point_flag <= 1'b0;
            flags_r.new_entry_flag     <= 1'b0;
            flags_r.muldiv_select_flag <= 1'b1;
            if (key_kind_r == KEY_MUL) begin
              flags_r.multiply_select_flag <= 1'b1;
              flags_r.constant_flag        <= 1'b1;
            end else begin
              flags_r.multiply_select_flag <= 1'b0;
              flags_r.constant_flag        <= 1'b0;
            end
          end
          default: ;
        endcase
      end
    end
  end

  // Halt indication and head drive
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      halted_out             <= 1'b0;
      head_column_output_out <= '0;
      head_row_out           <= '0;
      print_busy_out         <= 1'b0;
    end else if (ce_in) begin
      halted_out             <= top_busy;
      print_busy_out         <= tm_active;
      head_column_output_out <= tm_active ? cg_cols : '0;
      head_row_out           <= tm_active ? `CKE_ROWS'(1) << tm_row : '0;
    end
  end

  cke_print_timing #(
    .ROWS  (`CKE_ROWS),
    .DWELL (DWELL)
  ) u_timing (
    .core_clk_in (core_clk_in),
    .resetn_in   (resetn_in),
    .ce_in       (ce_in),
    .start_in    (print_start),
    .active_out  (tm_active),
    .row_out     (tm_row),
    .done_out    (tm_done)
  );
  cke_character_generator u_cg (
    .code_in  (input_register_r.code),
    .row_in   (tm_row),
    .cols_out (cg_cols)
  );

  AST_STATE_WORD_END: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    (state_r != $past(state_r) && !$past(clear_key_in)) |-> $past(word_end))
    else $error("state changed away from word end");
  AST_HALT_NO_PRINT: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    (state_r == ST_ZERO && top_busy && !clear_key_in && ce_in) |=> state_r == ST_ZERO)
    else $error("left idle with top digit loaded");
  AST_KEY_LOAD: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    (key_take && ce_in && !clear_key_in && key_in.kind == KEY_NUMERAL) |=>
      (input_register_r.code == $past(key_in.digit) && input_register_r.in_number))
    else $error("numeral code not loaded");
  AST_FIRST_DIGIT_CLEAR: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    (state_r == ST_FIVE && !flags_r.new_entry_flag && word_end && ce_in && !clear_key_in) |=>
      (flags_r.new_entry_flag && point_counter_r == `CKE_POINT_PRESET && entry_buffer_r == '0))
    else $error("first digit preparation wrong");
  AST_FRACTION_DECREMENT: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    (state_r == ST_FIVE && flags_r.new_entry_flag && flags_r.decimal_point_flag &&
     point_counter_r != `CKE_POINT_ZERO && word_end && ce_in && !clear_key_in) |=>
      point_counter_r == $past(point_counter_r) - 1'b1)
    else $error("point counter not decremented");
  AST_MUL_FLAGS: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    (state_r == ST_FOUR && key_kind_r == KEY_MUL && word_end && ce_in && !clear_key_in) |=>
      (flags_r.muldiv_select_flag && flags_r.multiply_select_flag && flags_r.constant_flag &&
       !flags_r.decimal_point_flag && !flags_r.new_entry_flag))
    else $error("multiply flags wrong");
  AST_DIV_FLAGS: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    (state_r == ST_FOUR && key_kind_r == KEY_DIV && word_end && ce_in && !clear_key_in) |=>
      (flags_r.muldiv_select_flag && !flags_r.multiply_select_flag && !flags_r.constant_flag &&
       !flags_r.decimal_point_flag && !flags_r.new_entry_flag))
    else $error("divide flags wrong");
  AST_RELEASE_RETURN: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    (state_r == ST_ONE && !(blank_pending_r && !flags_r.decimal_point_flag) &&
     key_release_signal_in && word_end && ce_in) |=> state_r == ST_ZERO)
    else $error("no return to idle after release");
  AST_HOLD_IN_ONE: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    (state_r == ST_ONE && !blank_pending_r && !key_release_signal_in && !clear_key_in) |=> state_r == ST_ONE)
    else $error("left wait state while key held");
  AST_COPY_TO_ACC: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    (state_r == ST_FOUR && word_end && ce_in && !clear_key_in) |=> upper_accumulator_r == entry_buffer_r)
    else $error("accumulator copy mismatch");
  AST_HEAD_IDLE: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    (!tm_active && ce_in) |=> (head_column_output_out == '0 && head_row_out == '0))
    else $error("head driven while not printing");
endmodule : cke_sequencer
`default_nettype wire

/* File: testbench/cke_keyboard_model.sv */
// Keyboard model: key-release level around each key press
`timescale 1ns/1ps
`default_nettype none
module cke_keyboard_model #(
  parameter int HOLD = 120
) (
  input  wire logic core_clk_in,
  input  wire logic press_in,
  output logic      key_release_signal_out
);
  int hold_cnt = 0;
  // Held long enough that the sequencer must sit in state one waiting
  assign key_release_signal_out = (hold_cnt == 0);
  always @(posedge core_clk_in) begin
    if (press_in) begin
      hold_cnt <= HOLD;
    end else if (hold_cnt > 0) begin
      hold_cnt <= hold_cnt - 1;
    end
  end
endmodule : cke_keyboard_model
`default_nettype wire

/* File: testbench/cke_sequencer_tb.sv */
// Self-checking bench for the key entry sequencer
`timescale 1ns/1ps
`default_nettype none
module cke_sequencer_tb;
  import cke_pkg::*;
  logic                core_clk_in = 1'b0, resetn_in = 1'b0, key_valid_in = 1'b0, clear_key_in = 1'b0;
  logic                key_rel, left, halted, busy, busy_seen;
  logic                ce = 1'b1;
  cke_key_t            key_in = '0;
  logic [3:0]          cols, point, col0;
  logic [4:0]          rows, row0;
  cke_state_t          state;
  cke_flags_t          flags;
  cke_input_reg_t      ir;
  logic [51:0]         buf_v, acc_v;
  int                  errors = 0, checks_done = 0;

  initial forever #2.5 core_clk_in = ~core_clk_in;

  cke_keyboard_model u_kbd (.core_clk_in(core_clk_in), .press_in(key_valid_in), .key_release_signal_out(key_rel));

  // Short row dwell keeps each print to one word cycle
  cke_sequencer #(.DIGITS(13), .DWELL(2)) u_dut (
    .core_clk_in(core_clk_in), .resetn_in(resetn_in), .ce_in(ce), .key_valid_in(key_valid_in),
    .key_in(key_in), .key_release_signal_in(key_rel), .clear_key_in(clear_key_in),
    .head_column_output_out(cols), .head_row_out(rows), .print_busy_out(busy), .state_out(state),
    .flags_out(flags), .input_register_out(ir), .entry_buffer_out(buf_v),
    .upper_accumulator_out(acc_v), .point_counter_out(point), .halted_out(halted));

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH t=%0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check

  task automatic give_verdict;
    $display("checks_done=%0d errors=%0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : give_verdict

  // One key stroke, then wait until the sequencer is back in state zero
  task automatic press(input cke_key_kind_t k, input logic [3:0] d);
    int n;
    @(negedge core_clk_in);
    key_in = '{kind: k, digit: d};
    key_valid_in = 1'b1;
    @(negedge core_clk_in);
    key_valid_in = 1'b0;
    left = 1'b0;
    row0 = '0;
    busy_seen = 1'b0;
    for (n = 0; n < 600 && !(left && state === ST_ZERO); n++) begin
      @(negedge core_clk_in);
      if (state !== ST_ZERO) left = 1'b1;
      if (busy === 1'b1) busy_seen = 1'b1;
      if (row0 === 5'h00 && rows !== 5'h00) begin
        row0 = rows;
        col0 = cols;
      end
    end
  endtask : press

  task automatic clear_key;
    @(negedge core_clk_in);
    clear_key_in = 1'b1;
    @(negedge core_clk_in);
    clear_key_in = 1'b0;
    repeat (3) @(negedge core_clk_in);
  endtask : clear_key

  initial begin
    repeat (6) @(negedge core_clk_in);
    resetn_in = 1'b1;
    check(point, 4'h4);
    check(flags, 6'h00);
    press(KEY_NUMERAL, 4'h5);
    check(ir, 5'h15);
    check(busy_seen, 1'b1);
    check(busy, 1'b0);
    check(row0, 5'h01);
    check(col0, 4'hF);
    check(buf_v, 52'h50000);
    check(flags, 6'h20);
    check(key_rel, 1'b1);
    press(KEY_NUMERAL, 4'h3);
    check(buf_v, 52'h530000);
    press(KEY_POINT, 4'h0);
    check(flags, 6'h30);
    check(buf_v, 52'h530000);
    press(KEY_NUMERAL, 4'h7);
    check(buf_v, 52'h537000);
    check(point, 4'h3);
    press(KEY_MUL, 4'h0);
    check(flags, 6'h0E);
    check(acc_v, 52'h537000);
    check(ir, 5'h0F);
    press(KEY_DIV, 4'h0);
    check(flags, 6'h02);
    clear_key();
    press(KEY_POINT, 4'h0);
    repeat (5) press(KEY_NUMERAL, 4'h1);
    check(halted, 1'b1);
    check(buf_v[51:48], 4'h1);
    press(KEY_NUMERAL, 4'h2);
    check(ir, 5'h11);
    check(left, 1'b0);
    check(busy_seen, 1'b0);
    press(KEY_MUL, 4'h0);
    check(state, ST_ZERO);
    check(flags, 6'h38);
    clear_key();
    check(halted, 1'b0);
    check(buf_v, 52'h0);
    // A key offered while the enable is low must leave the input register and the state alone
    @(negedge core_clk_in);
    ce = 1'b0;
    key_in = '{kind: KEY_NUMERAL, digit: 4'h9};
    key_valid_in = 1'b1;
    @(negedge core_clk_in);
    key_valid_in = 1'b0;
    repeat (20) @(negedge core_clk_in);
    check(ir, 5'h11);
    check(state, ST_ZERO);
    ce = 1'b1;
    give_verdict();
  end

  // Every stroke is bounded at about 600 cycles, so this is well past a normal run
  initial begin
    #(20000 * 5);
    errors++;
    give_verdict();
  end
endmodule : cke_sequencer_tb
`default_nettype wire
